// >>> hdl/dspu_pkg.sv
// Purpose: Constants and types shared by the serial debug port.
// Assumes: Byte-addressable 32-bit register port, 40 MHz system clock.
// Notes: One rule a line follows, each with its tag.
package dspu_pkg;
  localparam logic [31:0] TX_PORT_ADDR = 32'h1ffb8000;
  localparam logic [31:0] RX_PORT_ADDR = 32'h1ffb8004;
  localparam logic [31:0] CFG_ADDR = 32'h1ffb8008;
  localparam int CLK_HZ = 40000000;
  localparam int OVERSAMPLE = 16;
  localparam int BAUD_SLOW = 9600;
  localparam int BAUD_MID = 19200;
  localparam int BAUD_FAST = 38400;
  localparam int DIV_W = 16;
  // Truncating division makes every rate a little fast, never slow.
  localparam logic [15:0] DIV_SLOW = 16'(CLK_HZ / (OVERSAMPLE * BAUD_SLOW));
  localparam logic [15:0] DIV_MID = 16'(CLK_HZ / (OVERSAMPLE * BAUD_MID));
  localparam logic [15:0] DIV_FAST = 16'(CLK_HZ / (OVERSAMPLE * BAUD_FAST));
  localparam logic [1:0] BAUD_SEL_SLOW = 2'h0;
  localparam logic [1:0] BAUD_SEL_MID = 2'h1;
  localparam logic [1:0] BAUD_SEL_FAST = 2'h2;
  localparam int FIFO_DEPTH = 2;
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS = 10;
  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam int CFG_W = 6;
  localparam int CFG_TX_EN = 0;
  localparam int CFG_RX_EN = 1;
  localparam int CFG_WRAP = 2;
  localparam int CFG_IRQ_EN = 3;
  localparam int CFG_BAUD_LO = 4;
  localparam int CFG_BAUD_HI = 5;
  localparam int ST_IRQ = 15;
  localparam int ST_RX_VALID = 11;
  localparam int ST_RX_MORE = 10;
  localparam int ST_RX_OVF = 9;
  localparam int ST_FULL_FE = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
  localparam logic [31:0] REG_RESET = 32'h00000000;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } dspu_rx_state_type;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } dspu_tx_state_type;
endpackage

// >>> hdl/dspu_uart.sv
// Purpose: Serial debug port with two-byte transmit and receive FIFOs.
// Assumes: One request per cycle on the register port, answered next cycle.
// Notes: Line pins are plain level signals; the receive pin is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module dspu_uart #(
  parameter int DEPTH = dspu_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port.
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [3:0] bus_be,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic bus_ack_q,
  output logic [31:0] bus_rdata_q,
  // Interrupt requests.
  output logic tx_irq_q,
  output logic rx_irq_q,
  // Serial line.
  input wire logic rxd,
  output logic txd_q
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction
  function automatic logic [15:0] baud_div(input logic [1:0] sel);
    unique case (sel)
      dspu_pkg::BAUD_SEL_MID: baud_div = dspu_pkg::DIV_MID;
      dspu_pkg::BAUD_SEL_FAST: baud_div = dspu_pkg::DIV_FAST;
      default: baud_div = dspu_pkg::DIV_SLOW;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register decode and configuration.
  logic [dspu_pkg::CFG_W-1:0] cfg_q;
  logic tx_en, rx_en, wrap_en, irq_en;
  logic hit_tx, hit_rx, hit_cfg;
  logic tx_wr, tx_stat_rd, rx_data_rd, cfg_wr;
  assign tx_en = cfg_q[dspu_pkg::CFG_TX_EN];
  assign rx_en = cfg_q[dspu_pkg::CFG_RX_EN];
  assign wrap_en = cfg_q[dspu_pkg::CFG_WRAP];
  assign irq_en = cfg_q[dspu_pkg::CFG_IRQ_EN];
  assign hit_tx = bus_addr == dspu_pkg::TX_PORT_ADDR;
  assign hit_rx = bus_addr == dspu_pkg::RX_PORT_ADDR;
  assign hit_cfg = bus_addr == dspu_pkg::CFG_ADDR;
  assign tx_wr = bus_req && bus_we && bus_be[0] && hit_tx;
  assign tx_stat_rd = bus_req && !bus_we && bus_be[1] && hit_tx;
  assign rx_data_rd = bus_req && !bus_we && bus_be[0] && hit_rx;
  assign cfg_wr = bus_req && bus_we && bus_be[0] && hit_cfg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= dspu_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= bus_wdata[dspu_pkg::CFG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oversampling tick from the system clock.
  logic [dspu_pkg::DIV_W-1:0] div_cnt_q;
  logic tick;
  assign tick = div_cnt_q == '0;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_q <= '0;
    end else if (tick) begin
      div_cnt_q <= baud_div(cfg_q[dspu_pkg::CFG_BAUD_HI:dspu_pkg::CFG_BAUD_LO]) - 16'h0001;
    end else begin
      div_cnt_q <= div_cnt_q - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO.
  logic [7:0] tx_mem [DEPTH];
  logic [PW-1:0] tx_wp_q, tx_rp_q;
  logic [CW-1:0] tx_cnt_q;
  logic [7:0] tx_last_q;
  dspu_pkg::dspu_tx_state_type tx_state_q;
  logic tx_full, tx_accept, tx_direct, tx_push, tx_pop, tx_empty_evt;
  assign tx_full = tx_cnt_q == CNT_FULL;
  assign tx_accept = tx_wr && tx_en && !tx_full;
  assign tx_direct = tx_accept && tx_state_q == dspu_pkg::TX_IDLE && tx_cnt_q == '0;
  assign tx_push = tx_accept && !tx_direct;
  assign tx_pop = tx_en && tx_state_q == dspu_pkg::TX_IDLE && tx_cnt_q != '0;
  assign tx_empty_evt = tx_pop && tx_cnt_q == CNT_ONE && !tx_push;
  always_ff @(posedge sys_clk) begin
    if (tx_push) begin
      tx_mem[tx_wp_q] <= bus_wdata[7:0];
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= '0;
    end else if (!tx_en) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= '0;
    end else begin
      if (tx_push) begin
        tx_wp_q <= next_ptr(tx_wp_q);
      end
      if (tx_pop) begin
        tx_rp_q <= next_ptr(tx_rp_q);
      end
      if (tx_push && !tx_pop) begin
        tx_cnt_q <= tx_cnt_q + CNT_ONE;
      end else if (tx_pop && !tx_push) begin
        tx_cnt_q <= tx_cnt_q - CNT_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_last_q <= '0;
    end else if (tx_accept) begin
      tx_last_q <= bus_wdata[7:0];
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_irq_q <= 1'b0;
    end else if (tx_empty_evt && irq_en) begin
      tx_irq_q <= 1'b1;
    end else if (tx_stat_rd && tx_irq_q) begin
      tx_irq_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit shifter; an idle shifter holds all ones so the line rests high.
  logic [dspu_pkg::FRAME_BITS-1:0] tx_shift_q;
  logic [3:0] tx_tick_q, tx_bit_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_state_q <= dspu_pkg::TX_IDLE;
      tx_shift_q <= '1;
      tx_tick_q <= '0;
      tx_bit_q <= '0;
    end else if (!tx_en) begin
      tx_state_q <= dspu_pkg::TX_IDLE;
      tx_shift_q <= '1;
    end else begin
      unique case (tx_state_q)
        dspu_pkg::TX_IDLE: begin
          tx_tick_q <= '0;
          tx_bit_q <= '0;
          if (tx_direct || tx_pop) begin
            tx_state_q <= dspu_pkg::TX_SEND;
            tx_shift_q <= {1'b1, (tx_direct ? bus_wdata[7:0] : tx_mem[tx_rp_q]), 1'b0};
          end
        end
        dspu_pkg::TX_SEND: begin
          if (tick) begin
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_tick_q == dspu_pkg::LAST_TICK) begin
              tx_shift_q <= {1'b1, tx_shift_q[dspu_pkg::FRAME_BITS-1:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q == 4'(dspu_pkg::FRAME_BITS - 1)) begin
                tx_state_q <= dspu_pkg::TX_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txd_q <= 1'b1;
    end else begin
      txd_q <= (wrap_en || !tx_en) ? 1'b1 : tx_shift_q[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive line synchroniser and wrap selection.
  logic rx_meta_q, rx_sync_q, rx_prev_q, rx_line;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rxd;
      rx_sync_q <= rx_meta_q;
    end
  end
  assign rx_line = wrap_en ? tx_shift_q[0] : rx_sync_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_line;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive shifter.
  dspu_pkg::dspu_rx_state_type rx_state_q;
  logic [3:0] rx_tick_q, rx_bit_q;
  logic [7:0] rx_shift_q;
  logic rx_done_q, rx_done_fe_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_state_q <= dspu_pkg::RX_IDLE;
      rx_tick_q <= '0;
      rx_bit_q <= '0;
      rx_shift_q <= '0;
      rx_done_q <= 1'b0;
      rx_done_fe_q <= 1'b0;
    end else if (!rx_en) begin
      rx_state_q <= dspu_pkg::RX_IDLE;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      unique case (rx_state_q)
        dspu_pkg::RX_IDLE: begin
          rx_tick_q <= '0;
          rx_bit_q <= '0;
          if (rx_prev_q && !rx_line) begin
            rx_state_q <= dspu_pkg::RX_START;
          end
        end
        dspu_pkg::RX_START: begin
          if (tick) begin
            rx_tick_q <= rx_tick_q + 4'h1;
            if (rx_tick_q == dspu_pkg::MID_TICK) begin
              rx_tick_q <= '0;
              rx_state_q <= rx_line ? dspu_pkg::RX_IDLE : dspu_pkg::RX_DATA;
            end
          end
        end
        dspu_pkg::RX_DATA: begin
          if (tick) begin
            rx_tick_q <= rx_tick_q + 4'h1;
            if (rx_tick_q == dspu_pkg::LAST_TICK) begin
              rx_shift_q <= {rx_line, rx_shift_q[7:1]};
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == 4'(dspu_pkg::DATA_BITS - 1)) begin
                rx_state_q <= dspu_pkg::RX_STOP;
              end
            end
          end
        end
        dspu_pkg::RX_STOP: begin
          if (tick) begin
            rx_tick_q <= rx_tick_q + 4'h1;
            if (rx_tick_q == dspu_pkg::LAST_TICK) begin
              rx_done_q <= 1'b1;
              rx_done_fe_q <= !rx_line;
              rx_state_q <= dspu_pkg::RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO with presented byte at the head.
  logic [8:0] rx_mem [DEPTH];
  logic [PW-1:0] rx_wp_q, rx_rp_q;
  logic [CW-1:0] rx_cnt_q;
  logic rx_ovf_q, rx_push, rx_pop, rx_lost;
  assign rx_pop = rx_data_rd && rx_cnt_q != '0;
  assign rx_push = rx_done_q && (rx_cnt_q != CNT_FULL || rx_pop);
  assign rx_lost = rx_done_q && !rx_push;
  always_ff @(posedge sys_clk) begin
    if (rx_push) begin
      rx_mem[rx_wp_q] <= {rx_done_fe_q, rx_shift_q};
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= '0;
    end else if (!rx_en) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= '0;
    end else begin
      if (rx_push) begin
        rx_wp_q <= next_ptr(rx_wp_q);
      end
      if (rx_pop) begin
        rx_rp_q <= next_ptr(rx_rp_q);
      end
      if (rx_push && !rx_pop) begin
        rx_cnt_q <= rx_cnt_q + CNT_ONE;
      end else if (rx_pop && !rx_push) begin
        rx_cnt_q <= rx_cnt_q - CNT_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_ovf_q <= 1'b0;
    end else if (!rx_en) begin
      rx_ovf_q <= 1'b0;
    end else if (rx_lost) begin
      rx_ovf_q <= 1'b1;
    end else if (rx_pop) begin
      rx_ovf_q <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_irq_q <= 1'b0;
    end else if (rx_push && irq_en) begin
      rx_irq_q <= 1'b1;
    end else if (rx_cnt_q == '0) begin
      rx_irq_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and acknowledge.
  logic [31:0] rd_d;
  logic [8:0] rx_head;
  assign rx_head = rx_mem[rx_rp_q];
  always_comb begin
    rd_d = dspu_pkg::REG_RESET;
    if (hit_tx) begin
      rd_d[7:0] = tx_last_q;
      rd_d[dspu_pkg::ST_FULL_FE] = tx_full;
      rd_d[dspu_pkg::ST_IRQ] = tx_irq_q;
    end else if (hit_rx) begin
      if (rx_cnt_q != '0) begin
        rd_d[7:0] = rx_head[7:0];
        rd_d[dspu_pkg::ST_FULL_FE] = rx_head[8];
      end
      rd_d[dspu_pkg::ST_RX_OVF] = rx_ovf_q;
      rd_d[dspu_pkg::ST_RX_MORE] = rx_cnt_q > CNT_ONE;
      rd_d[dspu_pkg::ST_RX_VALID] = rx_cnt_q != '0;
      rd_d[dspu_pkg::ST_IRQ] = rx_irq_q;
    end else if (hit_cfg) begin
      rd_d[dspu_pkg::CFG_W-1:0] = cfg_q;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus_ack_q <= 1'b0;
      bus_rdata_q <= dspu_pkg::REG_RESET;
    end else begin
      bus_ack_q <= bus_req;
      if (bus_req && !bus_we) begin
        bus_rdata_q <= rd_d;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/dspu_uart_checker.sv
// Purpose: Port-level properties of the serial debug port.
// Assumes: Configuration is shadowed from register writes seen at the ports.
// Notes: Bound into every instance of the port.
`timescale 1ns/1ps
`default_nettype none
module dspu_uart_checker (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port.
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [3:0] bus_be,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_ack_q,
  input wire logic [31:0] bus_rdata_q,
  // Interrupts and line.
  input wire logic tx_irq_q,
  input wire logic rx_irq_q,
  input wire logic txd_q
);
  logic [5:0] cfg_q;
  logic first_q;
  logic rd_rx_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= 6'h00;
      first_q <= 1'b1;
      rd_rx_q <= 1'b0;
    end else begin
      first_q <= 1'b0;
      rd_rx_q <= bus_req && !bus_we && bus_addr == dspu_pkg::RX_PORT_ADDR;
      if (bus_req && bus_we && bus_be[0] && bus_addr == dspu_pkg::CFG_ADDR) begin
        cfg_q <= bus_wdata[5:0];
      end
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  property p_ack;
    bus_req |=> bus_ack_q;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_txclr;
    bus_req && !bus_we && bus_be[1] && bus_addr == dspu_pkg::TX_PORT_ADDR && tx_irq_q
      |=> bus_rdata_q[15] ##[0:1] !tx_irq_q;
  endproperty
  a_txclr: assert property (p_txclr) else $error("transmit irq not cleared");
  property p_rxempty;
    rd_rx_q && bus_ack_q && !bus_rdata_q[11] |-> ##[0:1] !rx_irq_q;
  endproperty
  a_rxempty: assert property (p_rxempty) else $error("receive irq with empty fifo");
  property p_rxirq;
    rd_rx_q && bus_ack_q && bus_rdata_q[15] |-> bus_rdata_q[11];
  endproperty
  a_rxirq: assert property (p_rxirq) else $error("receive irq without data");
  property p_wrap;
    cfg_q[2] && $past(cfg_q[2]) |-> txd_q;
  endproperty
  a_wrap: assert property (p_wrap) else $error("line driven in wrap mode");
  property p_txoff;
    !cfg_q[0] && !$past(cfg_q[0]) |-> txd_q;
  endproperty
  a_txoff: assert property (p_txoff) else $error("line driven while disabled");
  property p_rst;
    first_q |-> txd_q && !tx_irq_q && !rx_irq_q && !bus_ack_q;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset values");
  property p_gate;
    !cfg_q[3] && !$past(cfg_q[3]) |-> !$rose(rx_irq_q) && !$rose(tx_irq_q);
  endproperty
  a_gate: assert property (p_gate) else $error("irq raised while disabled");
endmodule
bind dspu_uart dspu_uart_checker u_dspu_uart_checker (.sys_clk, .resetn, .bus_req, .bus_we,
  .bus_be, .bus_addr, .bus_wdata, .bus_ack_q, .bus_rdata_q, .tx_irq_q, .rx_irq_q, .txd_q);
`default_nettype wire

// >>> test/dspu_term.sv
// Purpose: Serial terminal on the far end of the debug line.
// Assumes: Bit time matches the port's fastest rate.
// Notes: Holds the line high between characters.
`timescale 1ns/1ps
`default_nettype none
module dspu_term #(
  parameter int BIT_NS = 26000
) (
  // Line.
  input wire logic txd_q,
  output logic rxd,
  // Captured characters.
  output logic [7:0] got,
  output logic got_stb
);
  initial begin
    rxd = 1'b1;
    got = 8'h00;
    got_stb = 1'b0;
  end
  // Sends one character; bad pulls the stop bit low.
  task automatic send(input logic [7:0] d, input logic bad);
    rxd = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rxd = d[i];
      #(BIT_NS);
    end
    rxd = ~bad;
    #(BIT_NS);
    rxd = 1'b1;
  endtask
  always begin
    @(negedge txd_q);
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS);
      got[i] = txd_q;
    end
    #(BIT_NS);
    got_stb = txd_q;
    #1;
    got_stb = 1'b0;
  end
endmodule
`default_nettype wire

// >>> test/dspu_uart_tb_top.sv
// Purpose: Self-checking bench for the serial debug port.
// Assumes: Terminal model at the fastest rate; 25 ns clock.
// Notes: Reads note their expectation in a queue checked when the answer lands.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dspu_uart_tb_top;
  localparam logic [31:0] TXA = dspu_pkg::TX_PORT_ADDR;
  localparam logic [31:0] RXA = dspu_pkg::RX_PORT_ADDR;
  localparam logic [31:0] CFA = dspu_pkg::CFG_ADDR;
  logic sys_clk, resetn, bus_req, bus_we, bus_ack_q, tx_irq_q, rx_irq_q;
  logic rxd, txd_q, got_stb, rx_done;
  logic [3:0] bus_be;
  logic [31:0] bus_addr, bus_wdata, bus_rdata_q;
  logic [7:0] got, sx;
  logic [7:0] b [6];
  logic [7:0] ser_q [$];
  logic [63:0] exp_q [$];
  logic [63:0] m;
  int err_total, checked;
  dspu_uart u_dspu_uart (.sys_clk, .resetn, .bus_req, .bus_we, .bus_be, .bus_addr,
    .bus_wdata, .bus_ack_q, .bus_rdata_q, .tx_irq_q, .rx_irq_q, .rxd, .txd_q);
  dspu_term u_dspu_term (.txd_q, .rxd, .got, .got_stb);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  task automatic acc(input logic we, input logic [3:0] be, input logic [31:0] a,
      input logic [31:0] d, input logic [31:0] msk);
    @(posedge sys_clk);
    #1;
    bus_req = 1'b1;
    bus_we = we;
    bus_be = be;
    bus_addr = a;
    bus_wdata = d;
    exp_q.push_back({msk, d & msk});
    @(posedge sys_clk);
    #1;
    bus_req = 1'b0;
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wt(input int s);
    for (int i = 0; i < 40000; i++) begin
      @(posedge sys_clk);
      #1;
      if ((s == 0 && tx_irq_q === 1'b1) || (s == 1 && rx_done === 1'b1)) return;
    end
    err_total++;
    end_of_test();
  endtask
  always begin
    @(posedge sys_clk);
    #2;
    if (bus_ack_q === 1'b1) begin
      m = exp_q.pop_front();
      if (m[63:32] != 32'h0) `CHK(bus_rdata_q & m[63:32], m[31:0])
    end
  end
  always @(posedge got_stb) begin
    sx = ser_q.size() > 0 ? ser_q.pop_front() : 8'hxx;
    `CHK(got, sx)
  end
  ////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    bus_req = 1'b0;
    bus_we = 1'b0;
    bus_be = 4'h0;
    bus_addr = 32'h0;
    bus_wdata = 32'h0;
    rx_done = 1'b0;
    err_total = 0;
    checked = 0;
    void'($urandom(70));
    foreach (b[i]) b[i] = 8'($urandom);
    repeat (8) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    acc(0, 4'h1, TXA, 32'h0, '1);
    acc(0, 4'h1, RXA, 32'h0, '1);
    acc(0, 4'h1, CFA, 32'h0, '1);
    acc(0, 4'h1, TXA + 32'hc, 32'h0, '1);
    acc(1, 4'h1, CFA, 32'h2b, 32'h0);
    acc(0, 4'h1, CFA, 32'h2b, 32'h3f);
    fork
      begin
        u_dspu_term.send(b[4], 1'b0);
        u_dspu_term.send(b[5], 1'b0);
        u_dspu_term.send(8'h5a, 1'b0);
        rx_done = 1'b1;
      end
    join_none
    for (int i = 0; i < 3; i++) begin
      acc(1, 4'h1, TXA, {24'h0, b[i]}, 32'h0);
      ser_q.push_back(b[i]);
    end
    acc(0, 4'h1, TXA, {23'h0, 1'b1, b[2]}, 32'h1ff);
    acc(1, 4'h1, TXA, {24'h0, b[3]}, 32'h0);
    acc(0, 4'h1, TXA, {23'h0, 1'b1, b[2]}, 32'h1ff);
    wt(0);
    acc(0, 4'h2, TXA, 32'h8000, 32'h8000);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(tx_irq_q, 1'b0)
    wt(1);
    repeat (4) @(posedge sys_clk);
    acc(0, 4'h1, RXA, {16'h0, 8'h8e, b[4]}, 32'hffff);
    acc(0, 4'h1, RXA, {16'h0, 8'h88, b[5]}, 32'hffff);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(rx_irq_q, 1'b0)
    acc(0, 4'h1, RXA, 32'h0, 32'hffff);
    rx_done = 1'b0;
    fork
      begin
        u_dspu_term.send(b[3], 1'b1);
        rx_done = 1'b1;
      end
    join_none
    wt(1);
    repeat (4) @(posedge sys_clk);
    acc(0, 4'h2, RXA, 32'h8900, 32'hff00);
    acc(0, 4'h1, RXA, {16'h0, 8'h89, b[3]}, 32'hffff);
    acc(1, 4'h1, CFA, 32'h27, 32'h0);
    acc(1, 4'h1, TXA, {24'h0, b[1]}, 32'h0);
    repeat (11000) @(posedge sys_clk);
    acc(0, 4'h1, RXA, {16'h0, 8'h08, b[1]}, 32'hffff);
    acc(1, 4'h1, TXA, {24'h0, b[2]}, 32'h0);
    repeat (11000) @(posedge sys_clk);
    acc(1, 4'h1, CFA, 32'h25, 32'h0);
    acc(0, 4'h1, RXA, 32'h0, 32'hffff);
    acc(1, 4'h1, CFA, 32'h21, 32'h0);
    acc(1, 4'h1, TXA, {24'h0, b[0]}, 32'h0);
    repeat (100) @(posedge sys_clk);
    #1;
    `CHK(txd_q, 1'b0)
    acc(1, 4'h1, CFA, 32'h20, 32'h0);
    acc(1, 4'h1, TXA, {24'h0, b[5]}, 32'h0);
    acc(0, 4'h1, TXA, {24'h0, b[0]}, 32'hff);
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK(txd_q, 1'b1)
    `CHK(ser_q.size(), 0)
    end_of_test();
  end
endmodule
`default_nettype wire
